// *** logic/lcd_cmd_decoder.sv ***
// Command decoder, status read and display RAM access for the LCD driver.
// Overview of operation
// R1: Bytes 00H-4FH written as commands load the column address.
// R2: Data accesses step the column, stopping at 80, except reads in read-modify-write; page never steps.
// R3: Command-side read returns busy, segment order, display off, resetting, zeros.
// R4: Busy while executing or resetting; commands then ignored; host waits.
// R5: Segment-order status bit is one for normal, zero for inverted order.
// R6: Display status bit is one while the display is off.
// R7: Reset status bit is one while the reset command executes.
// R8: Data write stores at page and column, then steps the column.
// R9: Data read returns the latch, reloads it from RAM, steps the column outside read-modify-write.
// R10: Host discards one read after setting a new column address.
// R11: A0H/A1H select segment order; low bit one inverts.
// R12: A4H/A5H switch static drive, all commons selected unless in power save.
// R13: A8H/A9H select duty; low bit one is quarter, zero third.
// R14: E0H enters read-modify-write, saves column; only writes step the column.
// R15: End leaves read-modify-write and restores the saved column.
// R16: Host issues no column address set during read-modify-write.
// R17: E2H reinitialises start line, column and page; RAM kept.
// R18: Host must pulse the hardware reset pin at power-up.
// R19: Static drive on while display off enters power save.
// R20: Display on or static drive off leaves power save.
// R21: Select low means command or status, high means display data.
// R22: AEH/AFH switch the display off or on by the low bit.
// R23: Byte EEH as a command is End.
// R24: Reset sets start line to one, column and page to zero.
`timescale 1ns/1ps
module lcd_cmd_decoder #(
  parameter int CMD_BUSY_CYCLES   = lcd_pkg::CMD_BUSY_CYCLES,
  parameter int RESET_BUSY_CYCLES = lcd_pkg::RESET_BUSY_CYCLES
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hw_reset_pin_n,
  // Host parallel bus.
  input  wire logic        cmd_data_select,
  input  wire logic        rd_strobe_n,
  input  wire logic        wr_strobe_n,
  input  wire logic [7:0]  bus_data_in,
  output logic      [7:0]  bus_data_out,
  output logic             bus_data_oe,
  // Display control.
  output logic      [4:0]  start_line,
  output logic             seg_reverse,
  output logic             display_on,
  output logic             static_drive,
  output logic             duty_quarter,
  output logic             all_commons_select,
  output logic             lcd_drive_en,
  output logic             power_save,
  output logic             osc_out_pin_oe
);
  localparam int SW = 12;
  localparam int CW = 4;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUSY  = 3'b010,
    ST_RESET = 3'b100
  } lcd_state_t;

  function automatic logic cmd_is(input logic [7:0] b, input logic [7:0] code,
                                  input logic [7:0] mask);
    cmd_is = ((b & mask) == (code & mask));
  endfunction

  function automatic logic [6:0] col_step(input logic [6:0] c);
    col_step = (c < lcd_pkg::COL_STOP) ? 7'(c + 7'h01) : c;
  endfunction

  lcd_ram_if ram_bus ();

  // Pin synchronisers: three stages, a change counts once stages two and three agree.
  wire  [SW-1:0] pins_raw;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic [SW-1:0] sync3_reg;
  logic [SW-1:0] stable_reg;
  assign pins_raw = {hw_reset_pin_n, cmd_data_select, rd_strobe_n, wr_strobe_n, bus_data_in};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_reg[gi]  <= 1'b1;
          sync2_reg[gi]  <= 1'b1;
          sync3_reg[gi]  <= 1'b1;
          stable_reg[gi] <= 1'b1;
        end else begin
          sync1_reg[gi] <= pins_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            stable_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire       s_hw_rst_n = stable_reg[11];
  wire       s_sel      = stable_reg[10];
  wire       s_rd_n     = stable_reg[9];
  wire       s_wr_n     = stable_reg[8];
  wire [7:0] s_data     = stable_reg[7:0];

  lcd_state_t state_reg;
  lcd_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic       prev_rd_n_reg;
  logic       prev_wr_n_reg;
  logic       rd_sel_reg;
  logic [6:0] col_reg;
  logic [6:0] col_next;
  logic [6:0] col_saved_reg;
  logic [1:0] page_reg;
  logic [4:0] line_reg;
  logic       rmw_reg;
  logic       seg_rev_reg;
  logic       disp_on_reg;
  logic       static_reg;
  logic       duty_q_reg;
  logic [7:0] latch_reg;
  logic [7:0] dout_reg;
  logic       doe_reg;
  logic       ps_reg;
  logic       commons_reg;
  logic       run_reg;

  // Strobe edges and bus decode; select low is command or status, high is data. [R21]
  wire wr_start  = prev_wr_n_reg && !s_wr_n;
  wire rd_start  = prev_rd_n_reg && !s_rd_n;
  wire rd_end    = !prev_rd_n_reg && s_rd_n;
  wire idle      = (state_reg == ST_IDLE);
  wire cmd_take  = wr_start && !s_sel && idle && s_hw_rst_n; // [R4]
  wire dat_write = wr_start && s_sel && idle && s_hw_rst_n;
  wire dat_read  = rd_end && rd_sel_reg && idle && s_hw_rst_n;

  wire is_col    = cmd_take && (s_data <= lcd_pkg::CMD_COL_MAX); // [R1]
  wire is_disp   = cmd_take && cmd_is(s_data, lcd_pkg::CMD_DISP_CODE, lcd_pkg::CMD_LOWBIT_MASK);
  wire is_seg    = cmd_take && cmd_is(s_data, lcd_pkg::CMD_SEG_CODE, lcd_pkg::CMD_LOWBIT_MASK);
  wire is_static = cmd_take && cmd_is(s_data, lcd_pkg::CMD_STATIC_CODE, lcd_pkg::CMD_LOWBIT_MASK);
  wire is_duty   = cmd_take && cmd_is(s_data, lcd_pkg::CMD_DUTY_CODE, lcd_pkg::CMD_LOWBIT_MASK);
  wire is_page   = cmd_take && cmd_is(s_data, lcd_pkg::CMD_PAGE_CODE, lcd_pkg::CMD_PAGE_MASK);
  wire is_start  = cmd_take && cmd_is(s_data, lcd_pkg::CMD_START_CODE, lcd_pkg::CMD_START_MASK);
  wire is_rmw    = cmd_take && cmd_is(s_data, lcd_pkg::CMD_RMW_CODE, lcd_pkg::CMD_FULL_MASK);
  wire is_end    = cmd_take && cmd_is(s_data, lcd_pkg::CMD_END_CODE, lcd_pkg::CMD_FULL_MASK);
  wire is_reset  = cmd_take && cmd_is(s_data, lcd_pkg::CMD_RESET_CODE, lcd_pkg::CMD_FULL_MASK);

  // Status byte; the order bit reads one for normal order. [R3] [R5] [R6] [R7]
  wire [7:0] status_byte = {!idle || !s_hw_rst_n, !seg_rev_reg, !disp_on_reg,
                            (state_reg == ST_RESET) || !s_hw_rst_n, 4'h0};

  // Static drive with the display off is power save. [R19] [R20]
  wire disp_next   = is_disp ? s_data[0] : disp_on_reg;
  wire static_next = is_static ? s_data[0] : static_reg;
  wire ps_next     = static_next && !disp_next;

  // Column update: set, step on data access, restore on End. [R2] [R14] [R15] [R17]
  always_comb begin
    col_next = col_reg;
    if (is_reset) begin
      col_next = lcd_pkg::COL_INIT; // [R24]
    end else if (is_col) begin
      col_next = s_data[6:0]; // [R1]
    end else if (is_end && rmw_reg) begin
      col_next = col_saved_reg; // [R15]
    end else if (dat_write) begin
      col_next = col_step(col_reg); // [R8]
    end else if (dat_read && !rmw_reg) begin
      col_next = col_step(col_reg); // [R9]
    end
  end

  // Execution timer: every accepted command holds busy for a few cycles. [R4]
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (is_reset) begin
          state_next = ST_RESET; // [R7]
          cnt_next   = CW'(RESET_BUSY_CYCLES - 1);
        end else if (cmd_take) begin
          state_next = ST_BUSY;
          cnt_next   = CW'(CMD_BUSY_CYCLES - 1);
        end
      end
      ST_BUSY, ST_RESET: begin
        if (cnt_reg == '0) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = CW'(cnt_reg - 1'b1);
        end
      end
    endcase
  end

  assign ram_bus.wr_en = dat_write; // [R8]
  assign ram_bus.page  = page_reg;
  assign ram_bus.col   = col_reg;
  assign ram_bus.wdata = s_data;

  lcd_display_ram u_ram (
    .core_clk (core_clk),
    .ram      (ram_bus)
  );

  // Bus edge history and read select capture.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_rd_n_reg <= 1'b1;
      prev_wr_n_reg <= 1'b1;
      rd_sel_reg    <= 1'b0;
    end else begin
      prev_rd_n_reg <= s_rd_n;
      prev_wr_n_reg <= s_wr_n;
      if (rd_start) begin
        rd_sel_reg <= s_sel;
      end
    end
  end

  // Read path: status or the old latch goes out; the latch reloads after. [R3] [R9]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_reg  <= 8'h00;
      doe_reg   <= 1'b0;
      latch_reg <= 8'h00;
    end else begin
      doe_reg <= !s_rd_n;
      if (rd_start) begin
        dout_reg <= s_sel ? latch_reg : status_byte; // [R3]
      end
      if (dat_read) begin
        latch_reg <= ram_bus.rdata; // [R9]
      end
    end
  end

  // Address registers, modes and the execution timer.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= '0;
      col_reg       <= lcd_pkg::COL_INIT;
      col_saved_reg <= lcd_pkg::COL_INIT;
      page_reg      <= lcd_pkg::PAGE_INIT;
      line_reg      <= lcd_pkg::START_LINE_INIT;
      rmw_reg       <= 1'b0;
    end else if (!s_hw_rst_n) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= '0;
      col_reg       <= lcd_pkg::COL_INIT;
      col_saved_reg <= lcd_pkg::COL_INIT;
      page_reg      <= lcd_pkg::PAGE_INIT;
      line_reg      <= lcd_pkg::START_LINE_INIT;
      rmw_reg       <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      col_reg   <= col_next; // [R2]
      if (is_rmw) begin
        rmw_reg       <= 1'b1; // [R14]
        col_saved_reg <= col_reg;
      end else if (is_end) begin
        rmw_reg <= 1'b0; // [R23]
      end
      if (is_reset) begin
        page_reg <= lcd_pkg::PAGE_INIT; // [R17]
        line_reg <= lcd_pkg::START_LINE_INIT; // [R24]
      end else begin
        if (is_page) begin
          page_reg <= s_data[1:0];
        end
        if (is_start) begin
          line_reg <= s_data[4:0];
        end
      end
    end
  end

  // Display modes; the reset command leaves these untouched.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_rev_reg <= 1'b0;
      disp_on_reg <= 1'b0;
      static_reg  <= 1'b0;
      duty_q_reg  <= 1'b0;
      ps_reg      <= 1'b0;
      commons_reg <= 1'b0;
      run_reg     <= 1'b1;
    end else begin
      if (is_seg) begin
        seg_rev_reg <= s_data[0]; // [R11]
      end
      if (is_duty) begin
        duty_q_reg <= s_data[0]; // [R13]
      end
      disp_on_reg <= disp_next; // [R22]
      static_reg  <= static_next; // [R12]
      ps_reg      <= ps_next; // [R19] [R20]
      commons_reg <= static_next && !ps_next; // [R12]
      run_reg     <= !ps_next; // [R19] [R20]
    end
  end

  assign bus_data_out       = dout_reg;
  assign bus_data_oe        = doe_reg;
  assign start_line         = line_reg;
  assign seg_reverse        = seg_rev_reg;
  assign display_on         = disp_on_reg;
  assign static_drive       = static_reg;
  assign duty_quarter       = duty_q_reg;
  assign all_commons_select = commons_reg;
  assign lcd_drive_en       = run_reg;
  assign power_save         = ps_reg;
  assign osc_out_pin_oe     = run_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !s_hw_rst_n);

  sequence s_reset_taken;
    is_reset;
  endsequence
  sequence s_reset_busy;
    (state_reg == ST_RESET) [*4] ##1 idle;
  endsequence
  property p_col_set;
    is_col |=> (col_reg == $past(s_data[6:0]));
  endproperty
  a_col_set: assert property (p_col_set) else $error("column set not loaded"); // [R1]
  property p_col_limit;
    col_reg <= lcd_pkg::COL_STOP;
  endproperty
  a_col_limit: assert property (p_col_limit) else $error("column beyond 80"); // [R2]
  property p_status;
    rd_start && !s_sel |=> (bus_data_out == $past(status_byte)) && bus_data_oe;
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong"); // [R3]
  property p_busy_ignore;
    !idle && wr_start && !s_sel |=> $stable(col_reg) && $stable(seg_rev_reg);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy"); // [R4]
  property p_write_step;
    dat_write && (col_reg < lcd_pkg::COL_STOP) |=> (col_reg == $past(col_reg) + 7'h01);
  endproperty
  a_write_step: assert property (p_write_step) else $error("write did not step column"); // [R8]
  property p_rmw_read;
    dat_read && rmw_reg |=> $stable(col_reg) && (latch_reg == $past(ram_bus.rdata));
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("read moved column in rmw"); // [R14]
  property p_end_restore;
    is_end && rmw_reg |=> !rmw_reg && (col_reg == $past(col_saved_reg));
  endproperty
  a_end_restore: assert property (p_end_restore) else $error("end did not restore"); // [R15]
  property p_reset_cmd;
    s_reset_taken |=> (col_reg == 7'h00) && (page_reg == 2'h0) && (line_reg == 5'h01)
                      ##0 s_reset_busy;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command wrong"); // [R17]
  property p_power_save;
    (power_save == (static_drive && !display_on)) && (lcd_drive_en == !power_save);
  endproperty
  a_power_save: assert property (p_power_save) else $error("power save state wrong"); // [R19]
endmodule

// *** logic/lcd_display_ram.sv ***
// Display RAM held in flip-flops, one byte per page and column.
`timescale 1ns/1ps
module lcd_display_ram #(
  parameter int PAGES   = lcd_pkg::PAGES,
  parameter int COLUMNS = lcd_pkg::COLUMNS
) (
  // Clock.
  input wire logic   core_clk,
  // Access port.
  lcd_ram_if.mem     ram
);
  localparam int DEPTH = PAGES * COLUMNS;
  localparam int IDX_W = $clog2(DEPTH);

  logic [7:0]       mem_reg [DEPTH];
  wire  [IDX_W-1:0] index;
  wire              in_range;

  // Column 80 and beyond have no storage; writes there are dropped and reads give zero.
  assign in_range  = (int'(ram.col) < COLUMNS);
  assign index     = IDX_W'(int'(ram.page) * COLUMNS + int'(ram.col));
  assign ram.rdata = in_range ? mem_reg[index] : 8'h00;

  always_ff @(posedge core_clk) begin
    if (ram.wr_en && in_range) begin
      mem_reg[index] <= ram.wdata;
    end
  end
endmodule

// *** logic/lcd_pkg.sv ***
// Shared constants for the LCD driver command decoder.
package lcd_pkg;
  // Command codes and the masks that pick their fixed bits.
  localparam logic [7:0] CMD_COL_MAX     = 8'h4F;
  localparam logic [7:0] CMD_DISP_CODE   = 8'hAE;
  localparam logic [7:0] CMD_SEG_CODE    = 8'hA0;
  localparam logic [7:0] CMD_STATIC_CODE = 8'hA4;
  localparam logic [7:0] CMD_DUTY_CODE   = 8'hA8;
  localparam logic [7:0] CMD_LOWBIT_MASK = 8'hFE;
  localparam logic [7:0] CMD_PAGE_CODE   = 8'hB8;
  localparam logic [7:0] CMD_PAGE_MASK   = 8'hFC;
  localparam logic [7:0] CMD_START_CODE  = 8'hC0;
  localparam logic [7:0] CMD_START_MASK  = 8'hE0;
  localparam logic [7:0] CMD_RMW_CODE    = 8'hE0;
  localparam logic [7:0] CMD_END_CODE    = 8'hEE;
  localparam logic [7:0] CMD_RESET_CODE  = 8'hE2;
  localparam logic [7:0] CMD_FULL_MASK   = 8'hFF;
  // Status byte bit positions.
  localparam int STAT_BUSY_BIT  = 7;
  localparam int STAT_ORDER_BIT = 6;
  localparam int STAT_OFF_BIT   = 5;
  localparam int STAT_RESET_BIT = 4;
  // Geometry.
  localparam int PAGES     = 4;
  localparam int COLUMNS   = 80;
  localparam int COL_W     = 7;
  localparam int PAGE_W    = 2;
  localparam int LINE_W    = 5;
  localparam logic [6:0] COL_STOP = 7'h50;
  // Reset values.
  localparam logic [6:0] COL_INIT        = 7'h00;
  localparam logic [1:0] PAGE_INIT       = 2'h0;
  localparam logic [4:0] START_LINE_INIT = 5'h01;
  // Execution times in core clock cycles.
  localparam int CMD_BUSY_CYCLES   = 2;
  localparam int RESET_BUSY_CYCLES = 4;
  localparam int SYNC_STAGES       = 3;
endpackage

// *** logic/lcd_ram_if.sv ***
// Port bundle between the decoder and the display RAM.
`timescale 1ns/1ps
interface lcd_ram_if;
  logic                        wr_en;
  logic [lcd_pkg::PAGE_W-1:0]  page;
  logic [lcd_pkg::COL_W-1:0]   col;
  logic [7:0]                  wdata;
  logic [7:0]                  rdata;
  modport ctrl (output wr_en, output page, output col, output wdata, input rdata);
  modport mem  (input wr_en, input page, input col, input wdata, output rdata);
endinterface

// *** sim/lcd_cmd_decoder_tb.sv ***
// Self-checking testbench for the LCD driver command decoder.
`timescale 1ns/1ps
module lcd_cmd_decoder_tb;
  logic       core_clk;
  logic       rst_n;
  logic       hw_reset_pin_n;
  logic       cmd_data_select;
  logic       rd_strobe_n;
  logic       wr_strobe_n;
  logic [7:0] bus_data_in;
  logic [7:0] bus_data_out;
  logic       bus_data_oe;
  logic [4:0] start_line;
  logic       seg_reverse;
  logic       display_on;
  logic       static_drive;
  logic       duty_quarter;
  logic       all_commons_select;
  logic       lcd_drive_en;
  logic       power_save;
  logic       osc_out_pin_oe;
  int         n_errors;
  int         cmp_count;

  lcd_host_model host (
    .core_clk        (core_clk),
    .cmd_data_select (cmd_data_select),
    .rd_strobe_n     (rd_strobe_n),
    .wr_strobe_n     (wr_strobe_n),
    .bus_data_in     (bus_data_in),
    .bus_data_out    (bus_data_out),
    .bus_data_oe     (bus_data_oe),
    .hw_reset_pin_n  (hw_reset_pin_n)
  );

  lcd_cmd_decoder dut (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .hw_reset_pin_n     (hw_reset_pin_n),
    .cmd_data_select    (cmd_data_select),
    .rd_strobe_n        (rd_strobe_n),
    .wr_strobe_n        (wr_strobe_n),
    .bus_data_in        (bus_data_in),
    .bus_data_out       (bus_data_out),
    .bus_data_oe        (bus_data_oe),
    .start_line         (start_line),
    .seg_reverse        (seg_reverse),
    .display_on         (display_on),
    .static_drive       (static_drive),
    .duty_quarter       (duty_quarter),
    .all_commons_select (all_commons_select),
    .lcd_drive_en       (lcd_drive_en),
    .power_save         (power_save),
    .osc_out_pin_oe     (osc_out_pin_oe)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read answers must come with the output enable high.
  task automatic check_byte(input logic [8:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== {1'b1, exp}) begin
      n_errors++;
      $display("ERROR %0t read got %h expected 1%h", $time, got, exp);
    end
  endtask

  task automatic check_out(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t output got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic sel, input logic [7:0] exp);
    logic [8:0] r;
    host.read_byte(sel, r);
    check_byte(r, exp);
  endtask

  task automatic wr(input logic [7:0] data);
    host.write_byte(1'b1, data);
  endtask

  task automatic dummy();
    logic [8:0] r;
    host.read_byte(1'b1, r);
  endtask

  // Each command is followed by status polls until busy reads zero.
  task automatic cmd(input logic [7:0] code);
    logic [8:0] st;
    int n;
    host.write_byte(1'b0, code);
    n = 0;
    do begin
      host.read_byte(1'b0, st);
      n++;
    end while (st[7] !== 1'b0 && n < 20);
    check_out({7'h00, st[7]}, 8'h00);
  endtask

  // Display modes, power save and all three data paths in sequence.
  initial begin
    n_errors  = 0;
    cmp_count = 0;
    rst_n     = 1'b0;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (20) @(negedge core_clk);
    check_out({3'h0, start_line}, 8'h01);
    rd(1'b0, 8'h60);
    cmd(8'hA1);
    check_out({7'h00, seg_reverse}, 8'h01);
    rd(1'b0, 8'h20);
    cmd(8'hA0);
    check_out({7'h00, seg_reverse}, 8'h00);
    cmd(8'hA9);
    check_out({7'h00, duty_quarter}, 8'h01);
    cmd(8'hA8);
    check_out({7'h00, duty_quarter}, 8'h00);
    cmd(8'hAF);
    check_out({7'h00, display_on}, 8'h01);
    rd(1'b0, 8'h40);
    cmd(8'hA5);
    check_out({6'h00, static_drive, all_commons_select}, 8'h03);
    cmd(8'hAE);
    check_out({5'h00, power_save, lcd_drive_en, osc_out_pin_oe}, 8'h04);
    check_out({7'h00, all_commons_select}, 8'h00);
    cmd(8'hAF);
    check_out({5'h00, power_save, lcd_drive_en, all_commons_select}, 8'h03);
    cmd(8'hAE);
    check_out({7'h00, power_save}, 8'h01);
    cmd(8'hA4);
    check_out({6'h00, power_save, static_drive}, 8'h00);
    check_out({6'h00, lcd_drive_en, osc_out_pin_oe}, 8'h03);
    // Page 1, consecutive writes and reads from column 10H.
    cmd(8'hB9);
    cmd(8'h10);
    wr(8'hAA);
    wr(8'h55);
    wr(8'hC3);
    cmd(8'h10);
    dummy();
    rd(1'b1, 8'hAA);
    rd(1'b1, 8'h55);
    rd(1'b1, 8'hC3);
    // The column stops at 80: a write there is dropped and a read there loads zero.
    cmd(8'h4E);
    wr(8'h11);
    wr(8'h22);
    wr(8'h33);
    cmd(8'h4E);
    dummy();
    rd(1'b1, 8'h11);
    rd(1'b1, 8'h22);
    rd(1'b1, 8'h00);
    // Read-modify-write: reads hold the column, writes step it, End restores it.
    cmd(8'h20);
    wr(8'h01);
    wr(8'h02);
    cmd(8'h20);
    cmd(8'hE0);
    dummy();
    rd(1'b1, 8'h01);
    wr(8'h81);
    rd(1'b1, 8'h01);
    rd(1'b1, 8'h02);
    cmd(8'hEE);
    dummy();
    rd(1'b1, 8'h81);
    // Reset command sets line to one, column and page to zero, but keeps RAM and modes.
    cmd(8'hA1);
    cmd(8'hC5);
    check_out({3'h0, start_line}, 8'h05);
    cmd(8'hE2);
    check_out({3'h0, start_line}, 8'h01);
    check_out({7'h00, seg_reverse}, 8'h01);
    wr(8'h77);
    cmd(8'hB8);
    cmd(8'h00);
    dummy();
    rd(1'b1, 8'h77);
    cmd(8'hB9);
    cmd(8'h10);
    dummy();
    rd(1'b1, 8'hAA);
    cmd(8'hA0);
    // While the pin is low the device is busy, resetting and deaf to commands.
    host.set_pin(1'b0);
    repeat (6) @(negedge core_clk);
    rd(1'b0, 8'hF0);
    host.write_byte(1'b0, 8'hA1);
    host.set_pin(1'b1);
    repeat (8) @(negedge core_clk);
    check_out({7'h00, seg_reverse}, 8'h00);
    rd(1'b0, 8'h60);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule

// *** sim/lcd_host_model.sv ***
// Host processor model that drives the LCD driver's parallel bus and reset pin.
`timescale 1ns/1ps
module lcd_host_model (
  // Clock.
  input  wire logic       core_clk,
  // Parallel bus.
  output logic            cmd_data_select,
  output logic            rd_strobe_n,
  output logic            wr_strobe_n,
  output logic      [7:0] bus_data_in,
  input  wire logic [7:0] bus_data_out,
  input  wire logic       bus_data_oe,
  // Device reset pin.
  output logic            hw_reset_pin_n
);
  // Strobes stay low and high long enough to pass the device's input filter.
  localparam int STROBE_CYCLES = 6;

  initial begin
    cmd_data_select = 1'b0;
    rd_strobe_n     = 1'b1;
    wr_strobe_n     = 1'b1;
    bus_data_in     = 8'hA5;
    hw_reset_pin_n  = 1'b0;
    repeat (12) @(negedge core_clk);
    hw_reset_pin_n = 1'b1;
  end

  task automatic set_pin(input logic level);
    @(negedge core_clk);
    hw_reset_pin_n = level;
  endtask

  // Data is set one cycle ahead of the strobe and held until the strobe has risen.
  task automatic write_byte(input logic sel, input logic [7:0] data);
    @(negedge core_clk);
    cmd_data_select = sel;
    bus_data_in     = data;
    @(negedge core_clk);
    wr_strobe_n = 1'b0;
    repeat (STROBE_CYCLES) @(negedge core_clk);
    wr_strobe_n = 1'b1;
    repeat (STROBE_CYCLES) @(negedge core_clk);
    bus_data_in = ~data;
  endtask

  // The answer is taken while the strobe is still low, then the strobe is released.
  task automatic read_byte(input logic sel, output logic [8:0] result);
    @(negedge core_clk);
    cmd_data_select = sel;
    @(negedge core_clk);
    rd_strobe_n = 1'b0;
    repeat (STROBE_CYCLES) @(negedge core_clk);
    result      = {bus_data_oe, bus_data_out};
    rd_strobe_n = 1'b1;
    repeat (STROBE_CYCLES) @(negedge core_clk);
  endtask
endmodule
